// ---- pkg/stc_pkg.sv ----
// shared constants and types for the sixteen-bit timer core
package stc_pkg;
  // byte register selects on the cpu port
  localparam logic [3:0] SEL_CNT_L = 4'h0;
  localparam logic [3:0] SEL_CNT_H = 4'h1;
  localparam logic [3:0] SEL_CMPA_L = 4'h2;
  localparam logic [3:0] SEL_CMPA_H = 4'h3;
  localparam logic [3:0] SEL_CMPB_L = 4'h4;
  localparam logic [3:0] SEL_CMPB_H = 4'h5;
  localparam logic [3:0] SEL_CAP_L = 4'h6;
  localparam logic [3:0] SEL_CAP_H = 4'h7;
  localparam logic [3:0] SEL_CTRL_A = 4'h8;
  localparam logic [3:0] SEL_CTRL_B = 4'h9;
  localparam logic [3:0] SEL_CTRL_C = 4'ha;
  localparam logic [3:0] SEL_FLAG = 4'hb;
  localparam logic [3:0] SEL_IRQ_EN = 4'hc;
  // count limits
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [7:0] HOLD_RESET = 8'h00;
  // flag bit positions
  localparam int FLG_OVF = 0;
  localparam int FLG_MA = 1;
  localparam int FLG_MB = 2;
  localparam int FLG_CAP = 5;
  // top source selection (control a bits 1:0)
  typedef enum logic [1:0] {
    TOP_SRC_MAX = 2'b00,
    TOP_SRC_FIX = 2'b01,
    TOP_SRC_CMPA = 2'b10,
    TOP_SRC_CAP = 2'b11
  } stc_top_src_t;
  // clock select (control b bits 2:0)
  localparam logic [2:0] CS_NONE = 3'h0;
  localparam logic [2:0] CS_PRE = 3'h1;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int NOISE_LEN = 4;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] sel;
    logic [7:0] wdata;
  } stc_bus_t;
endpackage

// ---- core/stc_timer.sv ----
// sixteen-bit timer core with byte-wide cpu access
`timescale 1ns/10ps
// What this block does
// R1: count of zero is bottom.
// R2: count of all ones is maximum.
// R3: top is a fixed value, compare a, or capture value per mode.
// R4: sixteen-bit registers are reached as two byte accesses.
// R5: one shared eight-bit high-byte latch for all wide registers.
// R6: low-byte write loads latch and written byte in one cycle.
// R7: low-byte read copies high byte into latch; high read returns latch.
// R8: cpu writes high first and reads low first.
// R9: compare reads return contents directly, latch untouched.
// R10: software guards two-byte accesses against interrupt code.
// R11: both compare registers are checked against the count every cycle.
// R12: a compare match sets match flag a or b.
// R13: no selected clock source holds the count.
// R14: timer tick comes from prescaler or external pin, chosen edge.
// R15: selected capture edge copies count into capture value, except when the capture value is the top source.
// R16: capture input is filtered against short spikes.
// R17: compare a as top in pwm mode is double buffered and drives no output.
// R18: four flags in one register, each masked by an enable bit.
// R19: control registers are plain byte read/write.
// R20: cpu count write beats clear or count in that cycle.
// R21: capture flag sets with the capture copy.
// R22: high-byte latch resets to zero.
module stc_timer
  import stc_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  input wire stc_bus_t I_BUS,
  input wire logic I_PRE_TICK,
  input wire logic I_EXT_COUNT_PIN,
  input wire logic I_CAPTURE_PIN_A,
  input wire logic I_CAPTURE_PIN_B,
  input wire logic I_COMP_OUT,
  input wire logic I_FLAG_ACK_OVF,
  input wire logic I_FLAG_ACK_MA,
  input wire logic I_FLAG_ACK_MB,
  input wire logic I_FLAG_ACK_CAP,
  output logic [7:0] O_RDATA,
  output logic O_MATCH_A,
  output logic O_MATCH_B,
  output logic O_IRQ_OVF,
  output logic O_IRQ_MA,
  output logic O_IRQ_MB,
  output logic O_IRQ_CAP
);
  logic [15:0] cnt_reg, cnt_next, cmpa_reg, cmpa_next, cmpb_reg, cmpb_next;
  logic [15:0] cmpa_buf_reg, cmpa_buf_next, cmpb_buf_reg, cmpb_buf_next;
  logic [15:0] cap_reg, cap_next;
  logic [7:0] hold_reg, hold_next, ctla_reg, ctla_next, ctlb_reg, ctlb_next;
  logic [7:0] ctlc_reg, ctlc_next, flag_reg, flag_next, ien_reg, ien_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [1:0] ext_sync_reg, capa_sync_reg, capb_sync_reg, cmp_sync_reg;
  logic ext_last_reg, cap_filt_reg, cap_filt_next;
  logic [NOISE_LEN-1:0] cap_hist_reg;
  logic tick, top_hit, at_bottom, at_max, match_a, match_b, cap_src;
  logic cap_edge, cnt_wr, ovf_ev;
  logic [15:0] top_val;
  stc_top_src_t top_src;

  function automatic logic wr_sel(input stc_bus_t b, input logic [3:0] s);
    wr_sel = b.wr && (b.sel == s);
  endfunction

  // two-flop synchronisers for pin inputs
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ext_sync_reg <= 2'h0;
      capa_sync_reg <= 2'h0;
      capb_sync_reg <= 2'h0;
      cmp_sync_reg <= 2'h0;
      ext_last_reg <= 1'b0;
      cap_hist_reg <= '0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[0], I_EXT_COUNT_PIN};
      capa_sync_reg <= {capa_sync_reg[0], I_CAPTURE_PIN_A};
      capb_sync_reg <= {capb_sync_reg[0], I_CAPTURE_PIN_B};
      cmp_sync_reg <= {cmp_sync_reg[0], I_COMP_OUT};
      ext_last_reg <= ext_sync_reg[1];
      cap_hist_reg <= {cap_hist_reg[NOISE_LEN-2:0], cap_src};
    end
  end

  // clock selection and limits
  always_comb begin
    unique case (ctlb_reg[2:0])
      CS_NONE: tick = 1'b0; // R13
      CS_EXT_FALL: tick = ext_last_reg && !ext_sync_reg[1]; // R14
      CS_EXT_RISE: tick = !ext_last_reg && ext_sync_reg[1]; // R14
      default: tick = I_PRE_TICK; // R14
    endcase
    top_src = stc_top_src_t'(ctla_reg[1:0]);
    unique case (top_src)
      TOP_SRC_MAX: top_val = CNT_MAX;
      TOP_SRC_FIX: begin
        unique case (ctla_reg[3:2])
          2'h1: top_val = TOP_9BIT; // R3
          2'h2: top_val = TOP_10BIT; // R3
          default: top_val = TOP_8BIT; // R3
        endcase
      end
      TOP_SRC_CMPA: top_val = cmpa_reg; // R3 R17
      TOP_SRC_CAP: top_val = cap_reg; // R3
    endcase
    at_bottom = (cnt_reg == CNT_BOTTOM); // R1
    at_max = (cnt_reg == CNT_MAX); // R2
    top_hit = (cnt_reg == top_val);
    match_a = (cnt_reg == cmpa_reg); // R11
    match_b = (cnt_reg == cmpb_reg); // R11
    cap_src = ctlc_reg[6] ? cmp_sync_reg[1] :
              (ctlc_reg[7] ? capb_sync_reg[1] : capa_sync_reg[1]);
    cap_filt_next = cap_filt_reg;
    if (ctlb_reg[7]) begin
      if (&cap_hist_reg) cap_filt_next = 1'b1; // R16
      else if (~|cap_hist_reg) cap_filt_next = 1'b0; // R16
    end else begin
      cap_filt_next = cap_hist_reg[0];
    end
    // capture edge: bit 6 of control b picks rising
    cap_edge = ctlb_reg[6] ? (cap_filt_next && !cap_filt_reg)
                           : (!cap_filt_next && cap_filt_reg); // R15
  end

  // counter, compare, capture, latch and cpu registers
  always_comb begin
    cnt_wr = wr_sel(I_BUS, SEL_CNT_L);
    cnt_next = cnt_reg;
    ovf_ev = 1'b0;
    if (cnt_wr) begin
      cnt_next = {hold_reg, I_BUS.wdata}; // R6 R20
    end else if (tick) begin
      if (top_hit) begin
        cnt_next = CNT_BOTTOM;
        ovf_ev = 1'b1;
      end else begin
        cnt_next = cnt_reg + 16'h0001;
      end
    end
    hold_next = hold_reg;
    if (wr_sel(I_BUS, SEL_CNT_H) || wr_sel(I_BUS, SEL_CMPA_H) ||
        wr_sel(I_BUS, SEL_CMPB_H) || wr_sel(I_BUS, SEL_CAP_H)) begin
      hold_next = I_BUS.wdata; // R4 R5
    end
    if (I_BUS.rd && I_BUS.sel == SEL_CNT_L) hold_next = cnt_reg[15:8]; // R7
    if (I_BUS.rd && I_BUS.sel == SEL_CAP_L) hold_next = cap_reg[15:8]; // R7
    cmpa_buf_next = cmpa_buf_reg;
    cmpb_buf_next = cmpb_buf_reg;
    if (wr_sel(I_BUS, SEL_CMPA_L)) cmpa_buf_next = {hold_reg, I_BUS.wdata};
    if (wr_sel(I_BUS, SEL_CMPB_L)) cmpb_buf_next = {hold_reg, I_BUS.wdata};
    cmpa_next = cmpa_reg;
    cmpb_next = cmpb_reg;
    // double buffer: live in non-pwm mode, else update at top or bottom
    if (!ctla_reg[4] || (tick && (top_hit || at_bottom))) begin
      cmpa_next = cmpa_buf_next; // R17
      cmpb_next = cmpb_buf_next;
    end
    cap_next = cap_reg;
    if (wr_sel(I_BUS, SEL_CAP_L)) cap_next = {hold_reg, I_BUS.wdata}; // R6
    else if (cap_edge && top_src != TOP_SRC_CAP) cap_next = cnt_reg; // R15
    ctla_next = wr_sel(I_BUS, SEL_CTRL_A) ? I_BUS.wdata : ctla_reg; // R19
    ctlb_next = wr_sel(I_BUS, SEL_CTRL_B) ? I_BUS.wdata : ctlb_reg; // R19
    ctlc_next = wr_sel(I_BUS, SEL_CTRL_C) ? I_BUS.wdata : ctlc_reg; // R19
    ien_next = wr_sel(I_BUS, SEL_IRQ_EN) ? I_BUS.wdata : ien_reg; // R18
    // flags: write one or ack clears; a new event wins
    flag_next = flag_reg;
    if (wr_sel(I_BUS, SEL_FLAG)) flag_next = flag_reg & ~I_BUS.wdata;
    if (I_FLAG_ACK_OVF) flag_next[FLG_OVF] = 1'b0;
    if (I_FLAG_ACK_MA) flag_next[FLG_MA] = 1'b0;
    if (I_FLAG_ACK_MB) flag_next[FLG_MB] = 1'b0;
    if (I_FLAG_ACK_CAP) flag_next[FLG_CAP] = 1'b0;
    if (ovf_ev) flag_next[FLG_OVF] = 1'b1; // R18
    if (tick && match_a) flag_next[FLG_MA] = 1'b1; // R12
    if (tick && match_b) flag_next[FLG_MB] = 1'b1; // R12
    if (cap_next != cap_reg || (cap_edge && top_src != TOP_SRC_CAP)) begin
      if (!wr_sel(I_BUS, SEL_CAP_L)) flag_next[FLG_CAP] = 1'b1; // R21
    end
    flag_next = flag_next & 8'h27;
    rdata_next = rdata_reg;
    if (I_BUS.rd) begin
      unique case (I_BUS.sel)
        SEL_CNT_L: rdata_next = cnt_reg[7:0];
        SEL_CAP_L: rdata_next = cap_reg[7:0];
        SEL_CNT_H, SEL_CAP_H: rdata_next = hold_reg; // R7
        SEL_CMPA_L: rdata_next = cmpa_buf_reg[7:0]; // R9
        SEL_CMPA_H: rdata_next = cmpa_buf_reg[15:8]; // R9
        SEL_CMPB_L: rdata_next = cmpb_buf_reg[7:0]; // R9
        SEL_CMPB_H: rdata_next = cmpb_buf_reg[15:8]; // R9
        SEL_CTRL_A: rdata_next = ctla_reg; // R19
        SEL_CTRL_B: rdata_next = ctlb_reg; // R19
        SEL_CTRL_C: rdata_next = ctlc_reg; // R19
        SEL_FLAG: rdata_next = flag_reg; // R18
        SEL_IRQ_EN: rdata_next = ien_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cnt_reg <= 16'h0000;
      cmpa_reg <= 16'h0000;
      cmpb_reg <= 16'h0000;
      cmpa_buf_reg <= 16'h0000;
      cmpb_buf_reg <= 16'h0000;
      cap_reg <= 16'h0000;
      hold_reg <= HOLD_RESET; // R22
      ctla_reg <= 8'h00;
      ctlb_reg <= 8'h00;
      ctlc_reg <= 8'h00;
      flag_reg <= 8'h00;
      ien_reg <= 8'h00;
      rdata_reg <= 8'h00;
      cap_filt_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      cmpa_reg <= cmpa_next;
      cmpb_reg <= cmpb_next;
      cmpa_buf_reg <= cmpa_buf_next;
      cmpb_buf_reg <= cmpb_buf_next;
      cap_reg <= cap_next;
      hold_reg <= hold_next;
      ctla_reg <= ctla_next;
      ctlb_reg <= ctlb_next;
      ctlc_reg <= ctlc_next;
      flag_reg <= flag_next;
      ien_reg <= ien_next;
      rdata_reg <= rdata_next;
      cap_filt_reg <= cap_filt_next;
    end
  end

  assign O_RDATA = rdata_reg;
  // compare a drives no output when it is top in pwm mode
  assign O_MATCH_A = match_a && !(ctla_reg[4] && top_src == TOP_SRC_CMPA);
  assign O_MATCH_B = match_b;
  assign O_IRQ_OVF = flag_reg[FLG_OVF] && ien_reg[FLG_OVF]; // R18
  assign O_IRQ_MA = flag_reg[FLG_MA] && ien_reg[FLG_MA]; // R18
  assign O_IRQ_MB = flag_reg[FLG_MB] && ien_reg[FLG_MB]; // R18
  assign O_IRQ_CAP = flag_reg[FLG_CAP] && ien_reg[FLG_CAP]; // R18

  // one-cycle cpu strobes and counter events watched below
  sequence seq_cnt_low_write;
    wr_sel(I_BUS, SEL_CNT_L);
  endsequence
  sequence seq_cnt_low_read;
    I_BUS.rd && I_BUS.sel == SEL_CNT_L;
  endsequence
  sequence seq_cap_low_read;
    I_BUS.rd && I_BUS.sel == SEL_CAP_L;
  endsequence
  sequence seq_top_tick;
    tick && top_hit && !cnt_wr;
  endsequence

  chk_write_wins: assert property (@(posedge I_MCLK) // R20
    disable iff (!I_RSTN) seq_cnt_low_write
    |=> cnt_reg == {$past(hold_reg), $past(I_BUS.wdata)})
    else $error("count write lost");
  chk_low_read_latch: assert property (@(posedge I_MCLK) // R7
    disable iff (!I_RSTN) seq_cnt_low_read
    |=> hold_reg == $past(cnt_reg[15:8])) else $error("latch miss");
  chk_cap_read_latch: assert property (@(posedge I_MCLK) // R7
    disable iff (!I_RSTN) seq_cap_low_read
    |=> hold_reg == $past(cap_reg[15:8]))
    else $error("capture latch miss");
  chk_high_read_data: assert property (@(posedge I_MCLK) // R7
    disable iff (!I_RSTN) I_BUS.rd && I_BUS.sel == SEL_CNT_H
    |=> O_RDATA == $past(hold_reg)) else $error("high read not latch");
  chk_cmp_read_keep: assert property (@(posedge I_MCLK) // R9
    disable iff (!I_RSTN) I_BUS.rd && I_BUS.sel == SEL_CMPA_L && !I_BUS.wr
    |=> $stable(hold_reg)) else $error("compare read moved latch");
  chk_cmp_read_data: assert property (@(posedge I_MCLK) // R9
    disable iff (!I_RSTN) I_BUS.rd && I_BUS.sel == SEL_CMPA_H
    |=> O_RDATA == $past(cmpa_buf_reg[15:8]))
    else $error("compare high read wrong");
  chk_stopped_hold: assert property (@(posedge I_MCLK) // R13
    disable iff (!I_RSTN) ctlb_reg[2:0] == CS_NONE && !cnt_wr
    |=> $stable(cnt_reg)) else $error("count moved while stopped");
  chk_max_wrap: assert property (@(posedge I_MCLK) // R2
    disable iff (!I_RSTN) tick && at_max && !cnt_wr
    |=> cnt_reg == CNT_BOTTOM) else $error("count kept past maximum");
  chk_top_wrap: assert property (@(posedge I_MCLK) // R1 R3
    disable iff (!I_RSTN) seq_top_tick
    |=> cnt_reg == CNT_BOTTOM && flag_reg[FLG_OVF])
    else $error("count kept past top");
  chk_pwm_hold: assert property (@(posedge I_MCLK) // R17
    disable iff (!I_RSTN) ctla_reg[4] && !(tick && (top_hit || at_bottom))
    |=> $stable(cmpa_reg)) else $error("pwm compare moved off top");
  chk_match_flag: assert property (@(posedge I_MCLK) // R12
    disable iff (!I_RSTN) tick && match_a |=> flag_reg[FLG_MA])
    else $error("match a flag not set");
  chk_match_b_flag: assert property (@(posedge I_MCLK) // R12
    disable iff (!I_RSTN) tick && match_b |=> flag_reg[FLG_MB])
    else $error("match b flag not set");
  chk_cap_flag: assert property (@(posedge I_MCLK) // R15 R21
    disable iff (!I_RSTN) cap_edge && top_src != TOP_SRC_CAP &&
    !wr_sel(I_BUS, SEL_CAP_L) |=> flag_reg[FLG_CAP] &&
    cap_reg == $past(cnt_reg)) else $error("capture flag late");
  chk_ctl_write: assert property (@(posedge I_MCLK) // R19
    disable iff (!I_RSTN) wr_sel(I_BUS, SEL_CTRL_B)
    |=> ctlb_reg == $past(I_BUS.wdata))
    else $error("control write lost");
  chk_hold_reset: assert property (@(posedge I_MCLK) // R22
    $rose(I_RSTN) |-> hold_reg == HOLD_RESET)
    else $error("latch not zero after reset");
  chk_irq_mask: assert property (@(posedge I_MCLK) // R18
    disable iff (!I_RSTN) ovf_ev |=> O_IRQ_OVF == ien_reg[FLG_OVF])
    else $error("overflow request not masked by enable");
endmodule

// ---- bench/stc_cpu_model.sv ----
// cpu-side byte bus model for the timer core
`timescale 1ns/10ps
module stc_cpu_model
  import stc_pkg::*;
(
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output stc_bus_t o_bus
);
  initial o_bus = '0;
  // one-cycle strobe, raised and dropped on falling edges
  task automatic put(input logic w, input logic [3:0] s, input logic [7:0] x);
    @(negedge i_clk);
    o_bus = '{wr: w, rd: !w, sel: s, wdata: x};
    @(negedge i_clk);
    o_bus = '0;
  endtask
  task automatic rd8(input logic [3:0] s, output logic [7:0] x);
    put(1'b0, s, 8'h00);
    x = i_rdata;
  endtask
  // high first, then low; one access at a time
  task automatic wr16(input logic [3:0] s, input logic [15:0] x);
    put(1'b1, s | 4'h1, x[15:8]);
    put(1'b1, s, x[7:0]);
  endtask
  // low first, then high
  task automatic rd16(input logic [3:0] s, output logic [15:0] x);
    rd8(s, x[7:0]);
    rd8(s | 4'h1, x[15:8]);
  endtask
endmodule

// ---- bench/sixteen_bit_timer_access_core_tb.sv ----
// self-checking bench for the sixteen-bit timer core
`timescale 1ns/10ps
module sixteen_bit_timer_access_core_tb
  import stc_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pre = 1'b0;
  logic ext = 1'b0;
  logic cap_a = 1'b0;
  logic [3:0] ack = 4'h0;
  stc_bus_t bus;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [15:0] v;
  logic ma, mb, iovf, ima, imb, icap;
  int err_total = 0;
  int checked = 0;
  logic [3:0] rsel [4] = '{SEL_CNT_L, SEL_CMPA_L, SEL_CMPB_L, SEL_CAP_L};
  logic [15:0] rval [4] = '{16'h01ff, 16'h0123, 16'ha5c3, 16'h8001};
  logic [7:0] tmode [5] = '{8'h00, 8'h01, 8'h05, 8'h09, 8'h02};
  logic [15:0] ttop [5] = '{CNT_MAX, TOP_8BIT, TOP_9BIT, TOP_10BIT, 16'h0123};
  always #20 clk = ~clk;
  stc_cpu_model u_cpu (.i_clk(clk), .i_rdata(rdata), .o_bus(bus));
  stc_timer dut_u (
    .I_MCLK(clk), .I_RSTN(rstn), .I_BUS(bus), .I_PRE_TICK(pre),
    .I_EXT_COUNT_PIN(ext), .I_CAPTURE_PIN_A(cap_a),
    .I_CAPTURE_PIN_B(1'b0), .I_COMP_OUT(1'b0),
    .I_FLAG_ACK_OVF(ack[0]), .I_FLAG_ACK_MA(ack[1]),
    .I_FLAG_ACK_MB(ack[2]), .I_FLAG_ACK_CAP(ack[3]),
    .O_RDATA(rdata), .O_MATCH_A(ma), .O_MATCH_B(mb), .O_IRQ_OVF(iovf),
    .O_IRQ_MA(ima), .O_IRQ_MB(imb), .O_IRQ_CAP(icap)
  );
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr8(input logic [3:0] s, input logic [7:0] x);
    u_cpu.put(1'b1, s, x);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk);
      pre = 1'b1;
      @(negedge clk);
      pre = 1'b0;
    end
  endtask
  // run needs under a thousand cycles
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
  initial begin
    idle(3);
    rstn = 1'b1;
    chk({12'h000, iovf, ima, imb, icap}, 16'h0000);
    u_cpu.rd16(SEL_CNT_L, v);
    chk(v, CNT_BOTTOM);
    wr8(SEL_CNT_L, 8'h3c);
    u_cpu.rd16(SEL_CNT_L, v);
    chk(v, 16'h003c);
    for (int i = 0; i < 4; i++) begin
      u_cpu.wr16(rsel[i], rval[i]);
      u_cpu.rd16(rsel[i], v);
      chk(v, rval[i]);
    end
    wr8(SEL_CMPB_H, 8'h77);
    wr8(SEL_CNT_L, 8'h11);
    u_cpu.rd8(SEL_CNT_L, d);
    u_cpu.rd8(SEL_CMPA_H, d);
    chk(16'(d), 16'h0001);
    u_cpu.rd8(SEL_CNT_H, d);
    chk(16'(d), 16'h0077);
    wr8(SEL_CTRL_C, 8'h80);
    u_cpu.rd8(SEL_CTRL_C, d);
    chk(16'(d), 16'h0080);
    wr8(SEL_CTRL_C, 8'h00);
    wr8(SEL_CTRL_B, 8'h01);
    wr8(SEL_IRQ_EN, 8'h01);
    for (int i = 0; i < 5; i++) begin
      wr8(SEL_CTRL_A, tmode[i]);
      u_cpu.wr16(SEL_CNT_L, ttop[i]);
      tick(1);
      u_cpu.rd16(SEL_CNT_L, v);
      chk(v, CNT_BOTTOM);
      u_cpu.rd8(SEL_FLAG, d);
      chk(16'(d[FLG_OVF]), 16'h0001);
      chk(16'(iovf), 16'h0001);
      wr8(SEL_FLAG, 8'hff);
    end
    wr8(SEL_CTRL_A, 8'h00);
    wr8(SEL_CTRL_B, 8'h00);
    u_cpu.wr16(SEL_CNT_L, 16'h0100);
    tick(3);
    u_cpu.rd16(SEL_CNT_L, v);
    chk(v, 16'h0100);
    wr8(SEL_CTRL_B, 8'h01);
    tick(3);
    u_cpu.rd16(SEL_CNT_L, v);
    chk(v, 16'h0103);
    wr8(SEL_CTRL_B, 8'h07);
    repeat (3) begin
      idle(3);
      ext = 1'b1;
      idle(3);
      ext = 1'b0;
    end
    idle(4);
    u_cpu.rd16(SEL_CNT_L, v);
    chk(v, 16'h0106);
    wr8(SEL_CTRL_B, 8'h01);
    wr8(SEL_CNT_H, 8'h00);
    fork
      u_cpu.put(1'b1, SEL_CNT_L, 8'h55);
      tick(1);
    join
    u_cpu.rd16(SEL_CNT_L, v);
    chk(v, 16'h0055);
    u_cpu.wr16(SEL_CMPB_L, 16'h0123);
    u_cpu.wr16(SEL_CNT_L, 16'h0123);
    chk({14'h0000, ma, mb}, 16'h0003);
    wr8(SEL_FLAG, 8'hff);
    wr8(SEL_IRQ_EN, 8'h02);
    tick(1);
    u_cpu.rd8(SEL_FLAG, d);
    chk(16'(d & 8'h06), 16'h0006);
    chk({14'h0000, ima, imb}, 16'h0002);
    @(negedge clk);
    ack = 4'h2;
    @(negedge clk);
    ack = 4'h0;
    idle(1);
    chk(16'(ima), 16'h0000);
    wr8(SEL_CTRL_A, 8'h12);
    u_cpu.wr16(SEL_CMPA_L, 16'h0050);
    u_cpu.wr16(SEL_CNT_L, 16'h0123);
    chk({14'h0000, ma, mb}, 16'h0001);
    tick(1);
    u_cpu.rd16(SEL_CNT_L, v);
    chk(v, CNT_BOTTOM);
    u_cpu.wr16(SEL_CNT_L, 16'h0050);
    tick(1);
    u_cpu.rd16(SEL_CNT_L, v);
    chk(v, CNT_BOTTOM);
    wr8(SEL_CTRL_A, 8'h00);
    wr8(SEL_CTRL_B, 8'h40);
    u_cpu.wr16(SEL_CNT_L, 16'h4321);
    wr8(SEL_FLAG, 8'hff);
    wr8(SEL_IRQ_EN, 8'h20);
    cap_a = 1'b1;
    idle(6);
    chk(16'(icap), 16'h0001);
    u_cpu.rd16(SEL_CAP_L, v);
    chk(v, 16'h4321);
    cap_a = 1'b0;
    wr8(SEL_CTRL_B, 8'hc0);
    u_cpu.wr16(SEL_CNT_L, 16'h1111);
    idle(4);
    cap_a = 1'b1;
    idle(2);
    cap_a = 1'b0;
    idle(8);
    u_cpu.rd16(SEL_CAP_L, v);
    chk(v, 16'h4321);
    cap_a = 1'b1;
    idle(10);
    u_cpu.rd16(SEL_CAP_L, v);
    chk(v, 16'h1111);
    give_verdict();
  end
endmodule
